/* bit_sync.sv */
// two-flop level synchroniser, one lane per bit
// assumes each lane holds for several clock edges
`timescale 1ns/10ps
module bit_sync #(
   parameter int W = 1
) (
   // destination clock and reset
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   // levels
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] hold_ff;

   // each lane: first flop feeds only the second
   for (genvar i = 0; i < W; i++) begin : g_lane
      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            meta_ff[i] <= 1'h0;
            hold_ff[i] <= 1'h0;
         end else begin
            meta_ff[i] <= d_in[i];
            hold_ff[i] <= meta_ff[i];
         end
      end
   end

   assign q_out = hold_ff;
endmodule : bit_sync

/* eeprom_rd_pkg.sv */
// constants and types for the eeprom read and status block
// assumes a two-wire master and a byte-wide array
package eeprom_rd_pkg;

   // array geometry
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 8;

   // device address byte layout
   localparam int          PRE_HI        = 7;
   localparam int          PRE_LO        = 4;
   localparam int          SEL_HI        = 3;
   localparam int          SEL_LO        = 1;
   localparam int          RW_POS        = 0;
   localparam int          MSB_POS       = 7;

   // preambles and codes
   localparam logic [3:0]  ARRAY_PRE     = 4'hA;
   localparam logic [3:0]  STATUS_PRE    = 4'h6;
   localparam logic        RW_READ       = 1'h1;
   localparam logic        LINE_ACK      = 1'h0;
   localparam logic [2:0]  LAST_BIT      = 3'h7;
   localparam logic [2:0]  FIRST_BIT     = 3'h0;
   localparam logic [2:0]  BIT_STEP      = 3'h1;
   localparam logic [7:0]  ADDR_STEP     = 8'h01;
   localparam logic [7:0]  ADDR_RST      = 8'h00;
   localparam logic [7:0]  QUERY_FILLER  = 8'hFF;
   localparam logic        LOWER_HALF    = 1'h0;
   localparam int          SYNC_W        = 7;
   localparam int          BACK_W        = 2;

   // link phases
   typedef enum logic [3:0] {
      LS_IDLE      = 4'h0,
      LS_DEV       = 4'h1,
      LS_ACK_DEV   = 4'h2,
      LS_WADDR     = 4'h3,
      LS_ACK_WADDR = 4'h4,
      LS_WDATA     = 4'h5,
      LS_ACK_WDATA = 4'h6,
      LS_RDATA     = 4'h7,
      LS_MACK      = 4'h8
   } link_phase_t;

   // synced pin levels
   typedef struct packed {
      logic       run;        // synchronised clock enable
      logic       rev_query;  // query asks reversible flag
      logic       perm;       // permanent flag programmed
      logic       rev;        // reversible flag programmed
      logic [2:0] strap;      // strap_select_bit2..0
   } link_pins_t;

   // link state, rising scl
   typedef struct packed {
      link_phase_t         phase;
      logic [2:0]          bit_cnt;
      logic [DATA_W-1:0]   shift;
      logic [DATA_W-1:0]   tx;
      logic [ADDR_W-1:0]   addr;
      logic                rd;
      logic                is_query;
      logic                drive;
      logic                start_seen;
      logic                stop_seen;
      logic                sent_tog;
      logic                busy;
   } link_state_t;

   // pin driver state, falling scl
   typedef struct packed {
      logic oe;
      logic level;
   } pin_state_t;

   // system-clock side state
   typedef struct packed {
      logic busy;
      logic sent_prev;
      logic sent_pulse;
   } host_state_t;

endpackage : eeprom_rd_pkg

/* eeprom_rd_sva.sv */
// port checker, eeprom read and status block
// assumes scl parks high between frames
`timescale 1ns/10ps
module eeprom_rd_sva (
   // clocks and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic scl_clk_in,
   // link and pins
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic strap_select_bit2_in,
   input wire logic strap_select_bit1_in,
   input wire logic strap_select_bit0_in,
   input wire logic permanent_protect_flag_in,
   input wire logic reversible_protect_flag_in,
   input wire logic rev_query_sel_in,
   input wire logic link_busy_out,
   input wire logic byte_sent_out
);
   logic       st_tog_ff;
   logic       st_seen_ff;
   logic       first_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic       st_new;
   logic [2:0] strap;
   logic       arr_hit;
   logic       qry_hit;
   logic       addr_end;

   // address byte decode at the first ack slot
   assign st_new   = st_tog_ff ^ st_seen_ff;
   assign strap    = {strap_select_bit2_in, strap_select_bit1_in, strap_select_bit0_in};
   assign arr_hit  = shift_ff[7:1] == {eeprom_rd_pkg::ARRAY_PRE, strap};
   assign qry_hit  = shift_ff == {eeprom_rd_pkg::STATUS_PRE, strap, eeprom_rd_pkg::RW_READ};
   assign addr_end = first_ff & ~st_new & (cnt_ff == 4'h8);

   // start: sda falls while scl high
   always_ff @(negedge sda_in or posedge sys_rst_in) begin
      if (sys_rst_in) st_tog_ff <= 1'h0;
      else if (scl_clk_in) st_tog_ff <= ~st_tog_ff;
   end

   // bit count, first-byte flag, shifter
   always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st_seen_ff <= 1'h0;
         first_ff   <= 1'h0;
         cnt_ff     <= 4'h0;
         shift_ff   <= 8'h00;
      end else begin
         st_seen_ff <= st_tog_ff;
         first_ff   <= st_new | (first_ff & (cnt_ff != 4'h9));
         cnt_ff     <= (st_new || cnt_ff == 4'h9) ? 4'h1 : cnt_ff + 4'h1;
         shift_ff   <= {shift_ff[6:0], sda_in};
      end
   end

   sda_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      sda_out == 1'h0) else $error("sda_out driven high");
   rst_quiet_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $fell(sys_rst_in) |-> !sda_oe_out && !link_busy_out && !byte_sent_out)
      else $error("outputs active after reset");
   addr_quiet_a: assert property (@(posedge scl_clk_in) disable iff (sys_rst_in)
      first_ff && !st_new && cnt_ff inside {[4'h1:4'h7]} |-> !sda_oe_out)
      else $error("data pulled during address byte");
   array_ack_a: assert property (@(posedge scl_clk_in) disable iff (sys_rst_in)
      addr_end && arr_hit |-> sda_oe_out) else $error("array address not acked");
   perm_query_a: assert property (@(posedge scl_clk_in) disable iff (sys_rst_in)
      addr_end && qry_hit && !rev_query_sel_in |-> sda_oe_out == !permanent_protect_flag_in)
      else $error("permanent query ack wrong");
   rev_query_a: assert property (@(posedge scl_clk_in) disable iff (sys_rst_in)
      addr_end && qry_hit && rev_query_sel_in |-> sda_oe_out == !reversible_protect_flag_in)
      else $error("reversible query ack wrong");
   stranger_nack_a: assert property (@(posedge scl_clk_in) disable iff (sys_rst_in)
      addr_end && !arr_hit && !qry_hit |-> !sda_oe_out) else $error("foreign byte acked");
   sent_pulse_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(byte_sent_out) |=> !byte_sent_out) else $error("byte_sent_out too long");
   sent_busy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      byte_sent_out |-> link_busy_out) else $error("byte sent outside frame");

   // main scenarios reached
   cover property (@(posedge scl_clk_in) addr_end && sda_oe_out);
   cover property (@(posedge scl_clk_in) addr_end && qry_hit && !sda_oe_out);
   cover property (@(posedge clk_in) byte_sent_out);
endmodule : eeprom_rd_sva

bind serial_eeprom_read_and_protect_status eeprom_rd_sva chk_u (.clk_in(clk_in),
   .sys_rst_in(sys_rst_in), .scl_clk_in(scl_clk_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .strap_select_bit2_in(strap_select_bit2_in),
   .strap_select_bit1_in(strap_select_bit1_in), .strap_select_bit0_in(strap_select_bit0_in),
   .permanent_protect_flag_in(permanent_protect_flag_in),
   .reversible_protect_flag_in(reversible_protect_flag_in),
   .rev_query_sel_in(rev_query_sel_in), .link_busy_out(link_busy_out),
   .byte_sent_out(byte_sent_out));

/* line_events.sv */
// start and stop catchers
// assumes scl is steady high while sda marks a start or stop
`timescale 1ns/10ps
module line_events (
   // bus lines and reset
   input  wire logic rst_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   // one toggle per condition
   output logic      start_tog_out,
   output logic      stop_tog_out
);
   logic start_ff;
   logic stop_ff;

   // start: data falls while the clock is high
   always_ff @(negedge sda_in or posedge rst_in) begin
      if (rst_in) begin
         start_ff <= 1'h0;
      end else if (scl_in) begin
         start_ff <= ~start_ff;
      end
   end

   // stop: data rises while the clock is high
   always_ff @(posedge sda_in or posedge rst_in) begin
      if (rst_in) begin
         stop_ff <= 1'h0;
      end else if (scl_in) begin
         stop_ff <= ~stop_ff;
      end
   end

   assign start_tog_out = start_ff;
   assign stop_tog_out  = stop_ff;
endmodule : line_events

/* link_master.sv */
// two-wire bus master model: frames, bytes and acknowledges
// assumes an open-drain data wire with its pull-up resolved outside
`timescale 1ns/10ps
module link_master (
   // serial clock and data pull-down
   output logic      scl_out,
   output logic      pull_low_out,
   // resolved data wire
   input  wire logic sda_in
);
   logic [7:0] rd_buf [16];

   // bus parked: clock high, wire released
   initial begin
      scl_out      = 1'h1;
      pull_low_out = 1'h0;
   end

   // free clocks, wire released
   task automatic idle(input int n);
      repeat (n) begin
         #7.5 scl_out = 1'h0;
         #7.5 scl_out = 1'h1;
      end
   endtask : idle

   // one bit, sampled at the rise
   task automatic bit_slot(input logic b, output logic seen);
      #2 pull_low_out = ~b;
      #5.5 scl_out = 1'h1;
      seen = sda_in;
      #7.5 scl_out = 1'h0;
   endtask : bit_slot

   // start: sda falls while scl high
   task automatic start_cond();
      #2 pull_low_out = 1'h0;
      #5.5 scl_out = 1'h1;
      #3 pull_low_out = 1'h1;
      #4.5 scl_out = 1'h0;
   endtask : start_cond

   // stop: sda rises while scl high
   task automatic stop_cond();
      #2 pull_low_out = 1'h1;
      #5.5 scl_out = 1'h1;
      #3 pull_low_out = 1'h0;
      idle(3);
   endtask : stop_cond

   // byte out, msb first; ack when pulled low
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
      bit_slot(1'h1, s);
      ack = (s === 1'h0);
   endtask : put_byte

   // byte in, then ack or nack
   task automatic get_byte(input logic mack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_slot(1'h1, d[i]);
      bit_slot(~mack, s);
   endtask : get_byte

   // read frame of n bytes
   task automatic read_run(input logic [7:0] dev, input int n, output logic ok);
      start_cond();
      put_byte(dev, ok);
      if (ok) for (int k = 0; k < n; k++) get_byte(k != n - 1, rd_buf[k]);
      stop_cond();
   endtask : read_run
endmodule : link_master

/* serial_eeprom_read_and_protect_status.sv */
// two-wire eeprom target: array reads, address load, flag queries
// assumes scl stops between frames and sda is open drain
//
// What this block does
// - read frame starts like write, direction high
// - counter keeps last address plus one
// - read counter wraps from top to zero
// - after read address ack, send current byte
// - device acks dummy write, then sends byte
// - master ack means increment and send next
// - permanent query acked only while flag clear
// - query byte 0110, strap bits, read bit
// - reversible query acked only while flag clear
// - acked query returns a meaningless filler byte
`timescale 1ns/10ps
module serial_eeprom_read_and_protect_status (
   // system clock domain
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   // serial link
   input  wire logic scl_clk_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   // address straps
   input  wire logic strap_select_bit2_in,
   input  wire logic strap_select_bit1_in,
   input  wire logic strap_select_bit0_in,
   // protect flag levels
   input  wire logic permanent_protect_flag_in,
   input  wire logic reversible_protect_flag_in,
   input  wire logic rev_query_sel_in,
   // activity seen on the system clock
   output logic      link_busy_out,
   output logic      byte_sent_out
);
   localparam int DEPTH = 2 ** eeprom_rd_pkg::ADDR_W;

   eeprom_rd_pkg::link_state_t  lk_ff;
   eeprom_rd_pkg::link_state_t  nxt_lk;
   eeprom_rd_pkg::pin_state_t   pin_ff;
   eeprom_rd_pkg::pin_state_t   nxt_pin;
   eeprom_rd_pkg::host_state_t  hs_ff;
   eeprom_rd_pkg::host_state_t  nxt_hs;
   eeprom_rd_pkg::link_pins_t   pins_raw;
   eeprom_rd_pkg::link_pins_t   pins;

   logic [eeprom_rd_pkg::DATA_W-1:0] mem_q [DEPTH];
   logic [eeprom_rd_pkg::DATA_W-1:0] byte_in;
   logic [eeprom_rd_pkg::DATA_W-1:0] rd_byte;
   logic [eeprom_rd_pkg::ADDR_W-1:0] mem_wa;
   logic [eeprom_rd_pkg::DATA_W-1:0] mem_wd;
   logic                             mem_we;
   logic                             start_tog;
   logic                             stop_tog;
   logic [eeprom_rd_pkg::BACK_W-1:0] back_q;
   logic [3:0]                       pre;
   logic [2:0]                       sel;
   logic                             rw;
   logic                             flag_set;
   logic                             lower_prot;

   // start and stop catchers
   line_events u_events (
      .rst_in        (sys_rst_in),
      .scl_in        (scl_clk_in),
      .sda_in        (sda_in),
      .start_tog_out (start_tog),
      .stop_tog_out  (stop_tog)
   );

   // pins and enable into the link domain
   assign pins_raw = '{run:       clk_en_in,
                       rev_query: rev_query_sel_in,
                       perm:      permanent_protect_flag_in,
                       rev:       reversible_protect_flag_in,
                       strap:     {strap_select_bit2_in, strap_select_bit1_in,
                                   strap_select_bit0_in}};

   bit_sync #(.W(eeprom_rd_pkg::SYNC_W)) u_pin_sync (
      .clk_in (scl_clk_in),
      .rst_in (sys_rst_in),
      .d_in   (pins_raw),
      .q_out  (pins)
   );

   // address byte fields and helpers
   assign byte_in    = {lk_ff.shift[eeprom_rd_pkg::MSB_POS-1:0], sda_in};
   assign pre        = byte_in[eeprom_rd_pkg::PRE_HI:eeprom_rd_pkg::PRE_LO];
   assign sel        = byte_in[eeprom_rd_pkg::SEL_HI:eeprom_rd_pkg::SEL_LO];
   assign rw         = byte_in[eeprom_rd_pkg::RW_POS];
   assign flag_set   = pins.rev_query ? pins.rev : pins.perm;
   assign lower_prot = (pins.perm | pins.rev) &&
                       (lk_ff.addr[eeprom_rd_pkg::ADDR_W-1] == eeprom_rd_pkg::LOWER_HALF);
   // queries send filler, reads the byte at the counter
   assign rd_byte    = lk_ff.is_query ? eeprom_rd_pkg::QUERY_FILLER
                                      : mem_q[lk_ff.addr];

   // link protocol per rising scl
   always_comb begin
      nxt_lk            = lk_ff;
      mem_we            = 1'h0;
      mem_wa            = lk_ff.addr;
      mem_wd            = byte_in;
      nxt_lk.start_seen = start_tog;
      nxt_lk.stop_seen  = stop_tog;
      if (!pins.run) begin
         nxt_lk = lk_ff;
      end else if (start_tog != lk_ff.start_seen) begin
         // first address bit of a new or repeated frame
         nxt_lk.phase    = eeprom_rd_pkg::LS_DEV;
         nxt_lk.bit_cnt  = eeprom_rd_pkg::BIT_STEP;
         nxt_lk.shift    = byte_in;
         nxt_lk.drive    = 1'h0;
         nxt_lk.is_query = 1'h0;
         nxt_lk.busy     = 1'h1;
      end else if (stop_tog != lk_ff.stop_seen) begin
         // stop seen while the clock was parked
         nxt_lk.phase = eeprom_rd_pkg::LS_IDLE;
         nxt_lk.drive = 1'h0;
         nxt_lk.busy  = 1'h0;
      end else begin
         unique case (lk_ff.phase)
            eeprom_rd_pkg::LS_IDLE: begin
               nxt_lk.drive = 1'h0;
               nxt_lk.busy  = 1'h0;
            end
            eeprom_rd_pkg::LS_DEV: begin
               nxt_lk.shift   = byte_in;
               nxt_lk.bit_cnt = 3'(lk_ff.bit_cnt + eeprom_rd_pkg::BIT_STEP);
               if (lk_ff.bit_cnt == eeprom_rd_pkg::LAST_BIT) begin
                  nxt_lk.bit_cnt = eeprom_rd_pkg::FIRST_BIT;
                  nxt_lk.rd      = (rw == eeprom_rd_pkg::RW_READ);
                  if (pre == eeprom_rd_pkg::ARRAY_PRE && sel == pins.strap) begin
                     nxt_lk.phase = eeprom_rd_pkg::LS_ACK_DEV;
                     nxt_lk.drive = 1'h1;
                  end else if (pre == eeprom_rd_pkg::STATUS_PRE && sel == pins.strap &&
                               rw == eeprom_rd_pkg::RW_READ && !flag_set) begin
                     // clear flag: acknowledge the query
                     nxt_lk.phase    = eeprom_rd_pkg::LS_ACK_DEV;
                     nxt_lk.is_query = 1'h1;
                     nxt_lk.drive    = 1'h1;
                  end else begin
                     // foreign or flag set: no ack
                     nxt_lk.phase = eeprom_rd_pkg::LS_IDLE;
                     nxt_lk.drive = 1'h0;
                     nxt_lk.busy  = 1'h0;
                  end
               end
            end
            eeprom_rd_pkg::LS_ACK_DEV: begin
               nxt_lk.bit_cnt = eeprom_rd_pkg::FIRST_BIT;
               if (lk_ff.rd) begin
                  // load byte at counter, drive its msb
                  nxt_lk.phase    = eeprom_rd_pkg::LS_RDATA;
                  nxt_lk.tx       = rd_byte;
                  nxt_lk.drive    = ~rd_byte[eeprom_rd_pkg::MSB_POS];
                  nxt_lk.sent_tog = ~lk_ff.sent_tog;
                  if (!lk_ff.is_query) begin
                     nxt_lk.addr = lk_ff.addr + eeprom_rd_pkg::ADDR_STEP;
                  end
               end else begin
                  nxt_lk.phase = eeprom_rd_pkg::LS_WADDR;
                  nxt_lk.drive = 1'h0;
               end
            end
            eeprom_rd_pkg::LS_WADDR: begin
               nxt_lk.shift   = byte_in;
               nxt_lk.bit_cnt = 3'(lk_ff.bit_cnt + eeprom_rd_pkg::BIT_STEP);
               if (lk_ff.bit_cnt == eeprom_rd_pkg::LAST_BIT) begin
                  // word address loads the counter
                  nxt_lk.addr  = byte_in;
                  nxt_lk.phase = eeprom_rd_pkg::LS_ACK_WADDR;
                  nxt_lk.drive = 1'h1;
               end
            end
            eeprom_rd_pkg::LS_ACK_WADDR, eeprom_rd_pkg::LS_ACK_WDATA: begin
               nxt_lk.phase   = eeprom_rd_pkg::LS_WDATA;
               nxt_lk.bit_cnt = eeprom_rd_pkg::FIRST_BIT;
               nxt_lk.drive   = 1'h0;
            end
            eeprom_rd_pkg::LS_WDATA: begin
               nxt_lk.shift   = byte_in;
               nxt_lk.bit_cnt = 3'(lk_ff.bit_cnt + eeprom_rd_pkg::BIT_STEP);
               if (lk_ff.bit_cnt == eeprom_rd_pkg::LAST_BIT) begin
                  // store unless lower half protected
                  mem_we       = ~lower_prot;
                  nxt_lk.addr  = lk_ff.addr + eeprom_rd_pkg::ADDR_STEP;
                  nxt_lk.phase = eeprom_rd_pkg::LS_ACK_WDATA;
                  nxt_lk.drive = 1'h1;
               end
            end
            eeprom_rd_pkg::LS_RDATA: begin
               nxt_lk.bit_cnt = 3'(lk_ff.bit_cnt + eeprom_rd_pkg::BIT_STEP);
               nxt_lk.tx      = {lk_ff.tx[eeprom_rd_pkg::MSB_POS-1:0], 1'h0};
               nxt_lk.drive   = ~lk_ff.tx[eeprom_rd_pkg::MSB_POS-1];
               if (lk_ff.bit_cnt == eeprom_rd_pkg::LAST_BIT) begin
                  // release the line for the master's answer
                  nxt_lk.phase   = eeprom_rd_pkg::LS_MACK;
                  nxt_lk.bit_cnt = eeprom_rd_pkg::FIRST_BIT;
                  nxt_lk.drive   = 1'h0;
               end
            end
            eeprom_rd_pkg::LS_MACK: begin
               nxt_lk.bit_cnt = eeprom_rd_pkg::FIRST_BIT;
               if (sda_in == eeprom_rd_pkg::LINE_ACK) begin
                  // master ack: next byte, counter wraps
                  nxt_lk.phase    = eeprom_rd_pkg::LS_RDATA;
                  nxt_lk.tx       = rd_byte;
                  nxt_lk.drive    = ~rd_byte[eeprom_rd_pkg::MSB_POS];
                  nxt_lk.sent_tog = ~lk_ff.sent_tog;
                  if (!lk_ff.is_query) begin
                     nxt_lk.addr = lk_ff.addr + eeprom_rd_pkg::ADDR_STEP;
                  end
               end else begin
                  // nack: line released until the next start
                  nxt_lk.phase = eeprom_rd_pkg::LS_IDLE;
                  nxt_lk.drive = 1'h0;
                  nxt_lk.busy  = 1'h0;
               end
            end
            default: begin
               nxt_lk.phase = eeprom_rd_pkg::LS_IDLE;
               nxt_lk.drive = 1'h0;
               nxt_lk.busy  = 1'h0;
            end
         endcase
      end
   end

   // link state on the rising serial clock
   always_ff @(posedge scl_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lk_ff <= '{phase: eeprom_rd_pkg::LS_IDLE, bit_cnt: eeprom_rd_pkg::FIRST_BIT,
                    shift: '0, tx: '0, addr: eeprom_rd_pkg::ADDR_RST, default: 1'h0};
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   // array storage, no reset
   always_ff @(posedge scl_clk_in) begin
      if (mem_we) begin
         mem_q[mem_wa] <= mem_wd;
      end
   end

   // pin driver changes on falling scl
   always_comb begin
      nxt_pin       = pin_ff;
      nxt_pin.level = 1'h0;
      if (pins.run) begin
         nxt_pin.oe = lk_ff.drive;
      end
   end

   always_ff @(negedge scl_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pin_ff <= '{default: 1'h0};
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   assign sda_out    = pin_ff.level; // open drain: only ever pulls low
   assign sda_oe_out = pin_ff.oe;

   // activity back to clk_in
   bit_sync #(.W(eeprom_rd_pkg::BACK_W)) u_back_sync (
      .clk_in (clk_in),
      .rst_in (sys_rst_in),
      .d_in   ({lk_ff.busy, lk_ff.sent_tog}),
      .q_out  (back_q)
   );

   // busy level, one pulse per byte sent
   always_comb begin
      nxt_hs = hs_ff;
      if (clk_en_in) begin
         nxt_hs.busy       = back_q[1];
         nxt_hs.sent_prev  = back_q[0];
         nxt_hs.sent_pulse = back_q[0] ^ hs_ff.sent_prev;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         hs_ff <= '{default: 1'h0};
      end else begin
         hs_ff <= nxt_hs;
      end
   end

   assign link_busy_out = hs_ff.busy;
   assign byte_sent_out = hs_ff.sent_pulse;
endmodule : serial_eeprom_read_and_protect_status

/* serial_eeprom_read_and_protect_status_tb_top.sv */
// self-checking bench for the serial eeprom read and status block
// assumes the master model and checker beside it
`timescale 1ns/10ps
module serial_eeprom_read_and_protect_status_tb_top;
   // query row: flag pins, address byte, expected ack
   typedef struct packed {
      logic       sel;
      logic       perm;
      logic       rev;
      logic [7:0] dev;
      logic       ack;
   } row_t;

   localparam logic [2:0] STRAP = 3'h5;

   logic       clk_in;
   logic       sys_rst_in;
   logic       scl_w;
   logic       pull_w;
   logic       sda_w;
   logic       sda_out_w;
   logic       sda_oe_w;
   logic [2:0] strap_w;
   logic       perm_w;
   logic       rev_w;
   logic       sel_w;
   logic       busy_w;
   logic       sent_w;
   int         err_count;
   int         checks;
   int         sent_cnt;
   row_t       rows [10];

   // open-drain wire with pull-up
   assign sda_w = (sda_oe_w ? sda_out_w : 1'h1) & ~pull_w;

   serial_eeprom_read_and_protect_status dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .clk_en_in(1'h1), .scl_clk_in(scl_w), .sda_in(sda_w), .sda_out(sda_out_w),
      .sda_oe_out(sda_oe_w), .strap_select_bit2_in(strap_w[2]),
      .strap_select_bit1_in(strap_w[1]), .strap_select_bit0_in(strap_w[0]),
      .permanent_protect_flag_in(perm_w), .reversible_protect_flag_in(rev_w),
      .rev_query_sel_in(sel_w), .link_busy_out(busy_w), .byte_sent_out(sent_w));

   link_master master_u (.scl_out(scl_w), .pull_low_out(pull_w), .sda_in(sda_w));

   function automatic logic [7:0] pat(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction : pat

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // eight known bytes written from base
   task automatic write_run(input logic [7:0] base);
      logic a;
      master_u.start_cond();
      master_u.put_byte({eeprom_rd_pkg::ARRAY_PRE, STRAP, 1'h0}, a);
      master_u.put_byte(base, a);
      for (int k = 0; k < 8; k++) master_u.put_byte(pat(base + k[7:0]), a);
      master_u.stop_cond();
   endtask : write_run

   // current address read of n bytes starting at addr
   task automatic read_check(input logic [7:0] addr, input int n);
      logic ok;
      master_u.read_run({eeprom_rd_pkg::ARRAY_PRE, STRAP, eeprom_rd_pkg::RW_READ}, n, ok);
      check("read ack", 8'h01, {7'h00, ok});
      for (int k = 0; k < n; k++) check("read byte", pat(addr + k[7:0]), master_u.rd_buf[k]);
   endtask : read_check

   // dummy write of the word address, repeated start, read
   task automatic rand_read(input logic [7:0] addr, input int n);
      logic a1;
      logic a2;
      master_u.start_cond();
      master_u.put_byte({eeprom_rd_pkg::ARRAY_PRE, STRAP, 1'h0}, a1);
      master_u.put_byte(addr, a2);
      check("dummy acks", 8'h03, {6'h00, a1, a2});
      read_check(addr, n);
   endtask : rand_read

   // system clock
   initial begin
      clk_in = 1'h0;
      forever #4 clk_in = ~clk_in;
   end

   // read bytes announced on the system clock
   always @(posedge clk_in) if (sent_w === 1'h1) sent_cnt++;

   // watchdog: many times the expected run
   initial begin
      #300000;
      err_count++;
      $display("ERROR watchdog expected done seen hang");
      report_and_stop();
   end

   // main sequence
   initial begin
      logic ok;
      sys_rst_in = 1'h1;
      strap_w    = STRAP;
      perm_w     = 1'h0;
      rev_w      = 1'h0;
      sel_w      = 1'h0;
      err_count  = 0;
      checks     = 0;
      sent_cnt   = 0;
      rows = '{'{1'h0, 1'h0, 1'h0, 8'h6B, 1'h1}, '{1'h0, 1'h1, 1'h0, 8'h6B, 1'h0},
               '{1'h1, 1'h0, 1'h0, 8'h6B, 1'h1}, '{1'h1, 1'h0, 1'h1, 8'h6B, 1'h0},
               '{1'h0, 1'h0, 1'h1, 8'h6B, 1'h1}, '{1'h1, 1'h1, 1'h0, 8'h6B, 1'h1},
               '{1'h0, 1'h0, 1'h0, 8'h6A, 1'h0}, '{1'h0, 1'h0, 1'h0, 8'h69, 1'h0},
               '{1'h0, 1'h0, 1'h0, 8'hA9, 1'h0}, '{1'h0, 1'h0, 1'h0, 8'h5B, 1'h0}};
      repeat (6) @(posedge clk_in);
      #1 sys_rst_in = 1'h0;
      master_u.idle(3);
      write_run(8'h00);
      write_run(8'hF8);
      // queries and refused addresses
      foreach (rows[i]) begin
         @(posedge clk_in);
         #1 sel_w = rows[i].sel;
         perm_w = rows[i].perm;
         rev_w  = rows[i].rev;
         master_u.idle(3);
         master_u.read_run(rows[i].dev, 1, ok);
         check("query ack", {7'h00, rows[i].ack}, {7'h00, ok});
         if (ok === 1'h1) check("query byte", eeprom_rd_pkg::QUERY_FILLER, master_u.rd_buf[0]);
      end
      @(posedge clk_in);
      #1 perm_w = 1'h0;
      rev_w = 1'h0;
      master_u.idle(3);
      // counter kept through the queries
      read_check(8'h00, 1);
      // random read over the top
      sent_cnt = 0;
      rand_read(8'hFE, 4);
      check("bytes sent", 8'h04, sent_cnt[7:0]);
      repeat (4) @(posedge clk_in);
      check("busy after stop", 8'h00, {7'h00, busy_w});
      read_check(8'h02, 2);
      // mid-run reset clears the counter
      @(posedge clk_in);
      #1 sys_rst_in = 1'h1;
      repeat (2) @(posedge clk_in);
      #1 check("outputs in reset", 8'h00, {5'h00, sda_oe_w, busy_w, sent_w});
      sys_rst_in = 1'h0;
      master_u.idle(3);
      read_check(8'h00, 1);
      report_and_stop();
   end
endmodule : serial_eeprom_read_and_protect_status_tb_top
